// *** fpa_pkg.sv ***
// constants for the fixed-point add datapath: register map, field layout,
// opcodes and reset values.
// assumes nothing; used by name (fpa_pkg::name) from the top level and the bench only.
package fpa_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_GPR_SEL = 8'h04;
  localparam logic [7:0] OFF_GPR_DATA = 8'h08;
  localparam logic [7:0] OFF_XER = 8'h0c;
  localparam logic [7:0] OFF_CR0 = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h1c;
  localparam logic [7:0] OFF_RESULT = 8'h20;

  // instruction field positions (bit 31 of the word is its msb)
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int RT_HI = 25;
  localparam int RT_LO = 21;
  localparam int RA_HI = 20;
  localparam int RA_LO = 16;
  localparam int RB_HI = 15;
  localparam int RB_LO = 11;
  localparam int OE_POS = 10;
  localparam int XO_HI = 9;
  localparam int XO_LO = 1;
  localparam int RC_POS = 0;
  localparam int IMM_HI = 15;
  localparam int IMM_LO = 0;

  // primary and extended opcodes
  localparam logic [5:0] OPC_ADD_IMM = 6'h0e;
  localparam logic [5:0] OPC_ADD_IMM_CARRY = 6'h0c;
  localparam logic [5:0] OPC_ADD_IMM_CARRY_REC = 6'h0d;
  localparam logic [5:0] OPC_ADD_IMM_SHIFT = 6'h0f;
  localparam logic [5:0] OPC_EXT_GROUP = 6'h1f;
  localparam logic [8:0] XO_ADD_EXTENDED = 9'h08a;

  // exception register bits
  localparam int XER_CA = 0;
  localparam int XER_OV = 1;
  localparam int XER_SO = 2;
  localparam logic [2:0] XER_RESET = 3'h0;

  // condition field 0 bits
  localparam int CR_SO = 0;
  localparam int CR_EQ = 1;
  localparam int CR_GT = 2;
  localparam int CR_LT = 3;
  localparam logic [3:0] CR0_RESET = 4'h0;

  // interrupt status bits
  localparam int EV_DONE = 0;
  localparam int EV_OVERFLOW = 1;
  localparam int EV_ILLEGAL = 2;
  localparam int EV_NUM = 3;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // register file shape and reset contents
  localparam int GPR_NUM = 32;
  localparam logic [31:0] GPR_RESET = 32'h0000_0000;
  localparam logic [4:0] GPR_SEL_RESET = 5'h00;
  localparam logic [4:0] GPR_ZERO_IDX = 5'h00;

endpackage

// *** fpa_alu_if.sv ***
// carrier between the issue logic and the adder core.
// assumes one clock domain; all signals are combinational.
`timescale 1ns/1ns
`default_nettype none
interface fpa_alu_if;
  logic [31:0] opa;
  logic [31:0] opb;
  logic cin;
  logic [31:0] sum;
  logic carry;
  logic ovf;
  logic lt;
  logic gt;
  logic eq;

  // issue side drives operands and reads results
  modport issue (output opa, opb, cin, input sum, carry, ovf, lt, gt, eq);
  // core side computes the sum and its flags
  modport core (input opa, opb, cin, output sum, carry, ovf, lt, gt, eq);
endinterface
`default_nettype wire

// *** fpa_adder.sv ***
// 32-bit adder core with carry in, carry out, signed overflow and sign flags.
// assumes the issue logic holds operands stable for the cycle it samples.
`timescale 1ns/1ns
`default_nettype none
module fpa_adder (
  // operand and result carrier
  fpa_alu_if.core alu
);
  logic [32:0] wide_sum;

  // unsigned 33-bit sum gives the carry out of bit 31
  assign wide_sum = {1'b0, alu.opa} + {1'b0, alu.opb} + {32'h0000_0000, alu.cin};
  assign alu.sum = wide_sum[31:0];
  assign alu.carry = wide_sum[32];

  // operands read as signed two's complement
  assign alu.ovf = (alu.opa[31] == alu.opb[31]) && (wide_sum[31] != alu.opa[31]);
  assign alu.lt = wide_sum[31];
  assign alu.eq = (wide_sum[31:0] == 32'h0000_0000);
  assign alu.gt = !wide_sum[31] && !alu.eq;
endmodule
`default_nettype wire

// *** fpa_top.sv ***
// fixed-point add datapath with its own register file, exception bits and
// condition field 0, reached and driven over an apb slave port.
// assumes an apb master on the same clock; one transfer executes at most one
// instruction, written as a whole word to the instruction register.
//
// What this block does
// - register operands are 32-bit signed two's complement integers.
// - adds run without privilege; general registers hold operands and results.
// - extended add writes source a plus source b plus carry to the target.
// - extended add with record updates field 0 from the result.
// - extended add with overflow-enable and record updates so, ov, ca and field 0.
// - extended add updates carry; overflow-enable adds so and ov; record adds field 0.
// - plain immediate add adds sign-extended 16-bit immediate to source register.
// - plain immediate add uses zero when register 0 is the source.
// - plain immediate add leaves field 0 and exception bits unchanged.
// - carrying immediate add sign-extends the 16-bit immediate before adding.
// - carrying immediate add updates carry and never touches field 0.
// - carrying immediate add with record also updates field 0.
// - shifted immediate add adds immediate with sixteen low zeros, zero for register 0.
`timescale 1ns/1ns
`default_nettype none
module fpa_top (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [2:0] PPROT_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // interrupt
  output logic IRQ_O
);

  fpa_alu_if alu ();

  // architectural and software-visible state
  logic [31:0] general_register [0:fpa_pkg::GPR_NUM-1];
  logic [4:0] gpr_sel;
  logic [2:0] xer;
  logic [3:0] cr0;
  logic [31:0] last_instr;
  logic [31:0] last_result;
  logic [2:0] irq_stat;
  logic [2:0] irq_en;

  // apb phase decode
  wire apb_setup;
  wire apb_done;
  wire wr_en;
  assign apb_setup = PSEL_I && !PENABLE_I;
  assign apb_done = PSEL_I && PENABLE_I && PREADY_O;
  assign wr_en = apb_done && PWRITE_I;

  // address decode
  wire sel_instr;
  wire sel_gsel;
  wire sel_gdata;
  wire sel_xer;
  wire sel_cr0;
  wire sel_stat;
  wire sel_en;
  wire sel_clr;
  wire sel_res;
  wire sel_any;
  assign sel_instr = (PADDR_I == fpa_pkg::OFF_INSTR);
  assign sel_gsel = (PADDR_I == fpa_pkg::OFF_GPR_SEL);
  assign sel_gdata = (PADDR_I == fpa_pkg::OFF_GPR_DATA);
  assign sel_xer = (PADDR_I == fpa_pkg::OFF_XER);
  assign sel_cr0 = (PADDR_I == fpa_pkg::OFF_CR0);
  assign sel_stat = (PADDR_I == fpa_pkg::OFF_IRQ_STAT);
  assign sel_en = (PADDR_I == fpa_pkg::OFF_IRQ_EN);
  assign sel_clr = (PADDR_I == fpa_pkg::OFF_IRQ_CLR);
  assign sel_res = (PADDR_I == fpa_pkg::OFF_RESULT);
  assign sel_any = sel_instr || sel_gsel || sel_gdata || sel_xer || sel_cr0 ||
                   sel_stat || sel_en || sel_clr || sel_res;

  // instruction fields, taken straight from the write data
  wire [31:0] instr;
  wire [5:0] opcode;
  wire [4:0] target_reg_index;
  wire [4:0] source_reg_a_index;
  wire [4:0] source_reg_b_index;
  wire [8:0] ext_opcode;
  wire oe_bit;
  wire record_bit;
  wire [15:0] imm;
  assign instr = PWDATA_I;
  assign opcode = instr[fpa_pkg::OPC_HI:fpa_pkg::OPC_LO];
  assign target_reg_index = instr[fpa_pkg::RT_HI:fpa_pkg::RT_LO];
  assign source_reg_a_index = instr[fpa_pkg::RA_HI:fpa_pkg::RA_LO];
  assign source_reg_b_index = instr[fpa_pkg::RB_HI:fpa_pkg::RB_LO];
  assign ext_opcode = instr[fpa_pkg::XO_HI:fpa_pkg::XO_LO];
  assign oe_bit = instr[fpa_pkg::OE_POS];
  assign record_bit = instr[fpa_pkg::RC_POS];
  assign imm = instr[fpa_pkg::IMM_HI:fpa_pkg::IMM_LO];

  // operation select; no privilege check gates any form, pprot is ignored
  wire is_addi;
  wire legacy_carrying_immediate_op;
  wire is_addic_rec;
  wire is_addis;
  wire is_adde;
  wire legal;
  assign is_addi = (opcode == fpa_pkg::OPC_ADD_IMM);
  assign legacy_carrying_immediate_op = (opcode == fpa_pkg::OPC_ADD_IMM_CARRY);
  assign is_addic_rec = (opcode == fpa_pkg::OPC_ADD_IMM_CARRY_REC);
  assign is_addis = (opcode == fpa_pkg::OPC_ADD_IMM_SHIFT);
  assign is_adde = (opcode == fpa_pkg::OPC_EXT_GROUP) &&
                   (ext_opcode == fpa_pkg::XO_ADD_EXTENDED);
  assign legal = is_addi || legacy_carrying_immediate_op || is_addic_rec ||
                 is_addis || is_adde;

  // execute strobe: a completed write of a legal opcode to the instruction register
  wire instr_go;
  wire exec;
  assign instr_go = wr_en && sel_instr;
  assign exec = instr_go && legal;

  // register file read ports
  wire [31:0] gpr_a;
  wire [31:0] gpr_b;
  assign gpr_a = general_register[source_reg_a_index];
  assign gpr_b = general_register[source_reg_b_index];

  // operand formation
  wire ra_is_zero;
  wire [31:0] sext_imm;
  wire [31:0] shift_imm;
  wire [31:0] op_a;
  assign ra_is_zero = (source_reg_a_index == fpa_pkg::GPR_ZERO_IDX);
  assign sext_imm = {{16{imm[15]}}, imm};
  assign shift_imm = {imm, 16'h0000};
  assign op_a = ((is_addi || is_addis) && ra_is_zero) ? 32'h0000_0000 : gpr_a;
  assign alu.opa = op_a;
  assign alu.opb = is_adde ? gpr_b : (is_addis ? shift_imm : sext_imm);
  assign alu.cin = is_adde ? xer[fpa_pkg::XER_CA] : 1'b0;

  fpa_adder u_adder (
    .alu(alu)
  );

  // which state each form updates
  wire upd_ca;
  wire upd_ov;
  wire upd_cr;
  assign upd_ca = is_adde || legacy_carrying_immediate_op || is_addic_rec;
  assign upd_ov = is_adde && oe_bit;
  assign upd_cr = (is_adde && record_bit) || is_addic_rec;

  // next exception bits: summary overflow is sticky until software clears it
  wire [2:0] exec_xer;
  assign exec_xer[fpa_pkg::XER_CA] = upd_ca ? alu.carry : xer[fpa_pkg::XER_CA];
  assign exec_xer[fpa_pkg::XER_OV] = upd_ov ? alu.ovf : xer[fpa_pkg::XER_OV];
  assign exec_xer[fpa_pkg::XER_SO] = xer[fpa_pkg::XER_SO] || (upd_ov && alu.ovf);

  // next condition field from the result and the new summary overflow
  wire [3:0] exec_cr0;
  assign exec_cr0[fpa_pkg::CR_LT] = alu.lt;
  assign exec_cr0[fpa_pkg::CR_GT] = alu.gt;
  assign exec_cr0[fpa_pkg::CR_EQ] = alu.eq;
  assign exec_cr0[fpa_pkg::CR_SO] = exec_xer[fpa_pkg::XER_SO];

  wire [2:0] next_xer;
  wire [3:0] next_cr0;
  assign next_xer = exec ? exec_xer : ((wr_en && sel_xer) ? PWDATA_I[2:0] : xer);
  assign next_cr0 = (exec && upd_cr) ? exec_cr0 : cr0;

  // exception and condition state
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      xer <= fpa_pkg::XER_RESET;
      cr0 <= fpa_pkg::CR0_RESET;
    end else begin
      xer <= next_xer;
      cr0 <= next_cr0;
    end
  end

  // general register file, one entry per generate block
  wire sw_gpr_wr;
  assign sw_gpr_wr = wr_en && sel_gdata;
  generate
    for (genvar gi = 0; gi < fpa_pkg::GPR_NUM; gi++) begin : g_gpr
      wire exec_hit;
      wire sw_hit;
      assign exec_hit = exec && (target_reg_index == 5'(gi));
      assign sw_hit = sw_gpr_wr && (gpr_sel == 5'(gi));
      always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          general_register[gi] <= fpa_pkg::GPR_RESET;
        end else if (exec_hit) begin
          general_register[gi] <= alu.sum;
        end else if (sw_hit) begin
          general_register[gi] <= PWDATA_I;
        end
      end
    end
  endgenerate

  // software-held registers and execution trace
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      gpr_sel <= fpa_pkg::GPR_SEL_RESET;
      last_instr <= 32'h0000_0000;
      last_result <= 32'h0000_0000;
      irq_en <= fpa_pkg::IRQ_RESET;
    end else begin
      if (wr_en && sel_gsel) begin
        gpr_sel <= PWDATA_I[4:0];
      end
      if (instr_go) begin
        last_instr <= instr;
      end
      if (exec) begin
        last_result <= alu.sum;
      end
      if (wr_en && sel_en) begin
        irq_en <= PWDATA_I[2:0];
      end
    end
  end

  // sticky events: a set in the clearing cycle wins
  wire [2:0] events;
  wire [2:0] clr_mask;
  wire [2:0] next_irq_stat;
  assign events[fpa_pkg::EV_DONE] = exec;
  assign events[fpa_pkg::EV_OVERFLOW] = exec && upd_ov && alu.ovf;
  assign events[fpa_pkg::EV_ILLEGAL] = instr_go && !legal;
  assign clr_mask = (wr_en && sel_clr) ? PWDATA_I[2:0] : 3'h0;
  assign next_irq_stat = (irq_stat & ~clr_mask) | events;

  // enable as it stands after this edge, so the level never lags an enable write
  wire [2:0] next_irq_en;
  assign next_irq_en = (wr_en && sel_en) ? PWDATA_I[2:0] : irq_en;

  // interrupt status and level output
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      irq_stat <= fpa_pkg::IRQ_RESET;
      IRQ_O <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      IRQ_O <= |(next_irq_stat & next_irq_en);
    end
  end

  // read mux; unmapped and write-only offsets read zero
  wire [31:0] rd_mux;
  assign rd_mux = sel_instr ? last_instr :
                  sel_gsel ? {27'h0000000, gpr_sel} :
                  sel_gdata ? general_register[gpr_sel] :
                  sel_xer ? {29'h00000000, xer} :
                  sel_cr0 ? {28'h0000000, cr0} :
                  sel_stat ? {29'h00000000, irq_stat} :
                  sel_en ? {29'h00000000, irq_en} :
                  sel_res ? last_result : 32'h0000_0000;

  // apb answer: ready and data are prepared in the setup cycle
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end else begin
      PREADY_O <= apb_setup;
      PSLVERR_O <= apb_setup && !sel_any;
      PRDATA_O <= (apb_setup && !PWRITE_I) ? rd_mux : 32'h0000_0000;
    end
  end

  // checks on the datapath
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_addi_keeps_flags: assert property (instr_go && is_addi |=> $stable(xer) && $stable(cr0))
    else $error("plain immediate add changed flags");

  a_addi_zero_base: assert property (instr_go && is_addi && ra_is_zero |=>
                                     last_result == $past(sext_imm))
    else $error("immediate add from register 0 did not use zero");

  a_imm_sign_ext: assert property (instr_go && (is_addi || legacy_carrying_immediate_op) &&
                                   !ra_is_zero |=>
                                   last_result == $past(gpr_a) + $past(sext_imm))
    else $error("immediate not sign extended");

  a_addis_shifted: assert property (instr_go && is_addis |=>
                                    last_result == $past(op_a) + {$past(imm), 16'h0000})
    else $error("shifted immediate sum wrong");

  a_adde_sum: assert property (instr_go && is_adde |=>
                               last_result == $past(gpr_a) + $past(gpr_b) +
                               {31'h00000000, $past(xer[fpa_pkg::XER_CA])})
    else $error("extended add sum wrong");

  a_addic_carry_only: assert property (instr_go && legacy_carrying_immediate_op |=>
                                       $stable(cr0) && xer[fpa_pkg::XER_CA] == $past(alu.carry))
    else $error("carrying immediate add flags wrong");

  a_adde_ov_update: assert property (instr_go && is_adde && oe_bit |=>
                                     xer[fpa_pkg::XER_OV] == $past(alu.ovf) &&
                                     xer[fpa_pkg::XER_SO] ==
                                     ($past(xer[fpa_pkg::XER_SO]) || $past(alu.ovf)))
    else $error("overflow bits not updated");

  a_adde_ov_hold: assert property (instr_go && is_adde && !oe_bit |=>
                                   $stable(xer[fpa_pkg::XER_OV]) &&
                                   $stable(xer[fpa_pkg::XER_SO]) &&
                                   xer[fpa_pkg::XER_CA] == $past(alu.carry))
    else $error("extended add without overflow enable wrong");

  a_record_cr0: assert property (instr_go && legal && upd_cr |=>
                                 cr0[fpa_pkg::CR_LT] == last_result[31] &&
                                 cr0[fpa_pkg::CR_EQ] == (last_result == 32'h0000_0000) &&
                                 cr0[fpa_pkg::CR_GT] ==
                                 (!last_result[31] && last_result != 32'h0000_0000) &&
                                 cr0[fpa_pkg::CR_SO] == xer[fpa_pkg::XER_SO])
    else $error("condition field not set from result");

  a_no_record_cr0: assert property (instr_go && is_adde && !record_bit |=> $stable(cr0))
    else $error("condition field changed without record");

  a_addic_rec_flags: assert property (instr_go && is_addic_rec |=>
                                      xer[fpa_pkg::XER_CA] == $past(alu.carry) &&
                                      cr0[fpa_pkg::CR_GT] == $past(alu.gt))
    else $error("carrying immediate add with record flags wrong");

  a_addis_keeps_flags: assert property (instr_go && is_addis |=> $stable(xer) && $stable(cr0))
    else $error("shifted immediate add changed flags");

  a_illegal_no_write: assert property (instr_go && !legal |=> $stable(last_result) && $stable(xer))
    else $error("illegal opcode changed result or exception bits");

  a_irq_level: assert property (##1 IRQ_O == |(irq_stat & irq_en))
    else $error("interrupt level mismatch");

endmodule
`default_nettype wire

// *** fpa_apb_host.sv ***
// apb master model standing in for the issuing processor.
// assumes one clock; the bench calls xfer for every register access.
`timescale 1ns/1ns
`default_nettype none
module fpa_apb_host (
  // clock
  input wire logic clk_i,
  // apb request
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic [2:0] pprot_o,
  // slave answer
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  // idle bus at time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
    pprot_o = 3'h0;
  end

  // setup, access held until pready, then release with stale data inverted
  task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= ad;
    pwdata_o <= wd;
    pprot_o <= wd[2:0];
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    rd = prdata_i;
    er = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    pwdata_o <= ~wd;
    paddr_o <= ~ad;
  endtask
endmodule
`default_nettype wire

// *** fpa_top_bench.sv ***
// self-checking bench for the fixed-point add datapath over apb.
// assumes the apb host model; a shadow register file predicts every result.
`timescale 1ns/1ns
`default_nettype none
module fpa_top_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] pprot;
  logic [31:0] general_register [32] = '{default: 32'h0};
  logic [2:0] xer = 3'h0;
  logic [3:0] cr0 = 4'h0;
  logic [2:0] stat = 3'h0;
  logic [31:0] res = 32'h0;
  logic [31:0] seed = 32'd15780;
  logic [5:0] ops [5] = '{6'h0e, 6'h0c, 6'h0d, 6'h0f, 6'h1f};
  logic [7:0] offs [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;

  fpa_apb_host fpa_apb_host_inst (.clk_i(clk), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .pprot_o(pprot),
    .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
  fpa_top fpa_top_inst (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PPROT_I(pprot),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq));

  // 100 mhz clock
  initial begin
    forever #5 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("FAIL %0t timeout", $time);
      results();
    end
  end

  // galois lfsr stepped over a whole word
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++) begin
      seed = seed[0] ? (seed >> 1) ^ 32'h8020_0003 : seed >> 1;
    end
    return seed;
  endfunction

  // instruction word builders
  function automatic logic [31:0] im(input logic [5:0] op, input logic [4:0] t, a,
                                     input logic [15:0] i);
    return {op, t, a, i};
  endfunction
  function automatic logic [31:0] ex(input logic [4:0] t, a, b, input logic oe, rc);
    return {fpa_pkg::OPC_EXT_GROUP, t, a, b, oe, fpa_pkg::XO_ADD_EXTENDED, rc};
  endfunction

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // register write and read with expected error flag
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
    logic [31:0] r;
    logic e;
    fpa_apb_host_inst.xfer(1'b1, a, d, r, e);
    check({31'h0, e}, {31'h0, err}, $sformatf("write error at %h", a));
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic err = 1'b0);
    logic [31:0] r;
    logic e;
    fpa_apb_host_inst.xfer(1'b0, a, 32'h0, r, e);
    check(r, exp, $sformatf("read at %h", a));
    check({31'h0, e}, {31'h0, err}, $sformatf("read error at %h", a));
  endtask

  // load two registers and the exception bits
  task automatic pre(input logic [4:0] a, input logic [31:0] va, input logic [4:0] b,
                     input logic [31:0] vb, input logic [2:0] c);
    wr(fpa_pkg::OFF_GPR_SEL, {27'h0, a});
    wr(fpa_pkg::OFF_GPR_DATA, va);
    general_register[a] = va;
    wr(fpa_pkg::OFF_GPR_SEL, {27'h0, b});
    wr(fpa_pkg::OFF_GPR_DATA, vb);
    general_register[b] = vb;
    wr(fpa_pkg::OFF_XER, {29'h0, c});
    xer = c;
  endtask

  // predict one instruction, issue it, compare instruction, result, target, exception bits, field 0 and status
  task automatic exec(input logic [31:0] w);
    logic [5:0] op;
    logic [4:0] t;
    logic [31:0] x, y;
    logic [32:0] f;
    logic ext, ovf;
    op = w[31:26];
    t = w[25:21];
    ext = op == 6'h1f && w[9:1] == 9'd138;
    x = ((op == 6'h0e || op == 6'h0f) && w[20:16] == 5'h00) ? 32'h0 : general_register[w[20:16]];
    y = ext ? general_register[w[15:11]] : op == 6'h0f ? {w[15:0], 16'h0000} : {{16{w[15]}}, w[15:0]};
    f = {1'b0, x} + {1'b0, y} + {32'h0, ext & xer[0]};
    ovf = x[31] == y[31] && f[31] != x[31];
    if (!ext && op[5:2] != 4'h3) begin
      stat[2] = 1'b1;
    end else begin
      stat[0] = 1'b1;
      res = f[31:0];
      general_register[t] = f[31:0];
      if (ext || op[5:1] == 5'h06) begin
        xer[0] = f[32];
      end
      if (ext && w[10]) begin
        xer[2:1] = {xer[2] | ovf, ovf};
        stat[1] = stat[1] | ovf;
      end
      if ((ext && w[0]) || op == 6'h0d) begin
        cr0 = {f[31], !f[31] && f[31:0] != 32'h0, f[31:0] == 32'h0, xer[2]};
      end
    end
    wr(fpa_pkg::OFF_INSTR, w);
    rdc(fpa_pkg::OFF_INSTR, w);
    rdc(fpa_pkg::OFF_RESULT, res);
    wr(fpa_pkg::OFF_GPR_SEL, {27'h0, t});
    rdc(fpa_pkg::OFF_GPR_DATA, general_register[t]);
    rdc(fpa_pkg::OFF_XER, {29'h0, xer});
    rdc(fpa_pkg::OFF_CR0, {28'h0, cr0});
    rdc(fpa_pkg::OFF_IRQ_STAT, {29'h0, stat});
  endtask

  // interrupt level against status and enable
  task automatic irqc(input logic [2:0] en);
    rdc(fpa_pkg::OFF_IRQ_EN, {29'h0, en});
    rdc(fpa_pkg::OFF_IRQ_STAT, {29'h0, stat});
    @(posedge clk);
    check({31'h0, irq}, {31'h0, |(stat & en)}, "interrupt level");
  endtask

  task automatic done(input string s);
    $display("test %s over", s);
  endtask

  // verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    logic [5:0] op;
    logic [31:0] v;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (offs[i]) rdc(offs[i], 32'h0);
    check({31'h0, irq}, 32'h0, "interrupt after reset");
    rdc(8'h24, 32'h0, 1'b1);
    wr(8'h24, 32'hffff_ffff, 1'b1);
    wr(fpa_pkg::OFF_CR0, 32'hffff_ffff);
    rdc(fpa_pkg::OFF_CR0, 32'h0);
    done("reset and refusals");
    pre(4, 32'h1000_0400, 10, 32'h1000_0400, 3'h1);
    exec(ex(6, 4, 10, 1'b0, 1'b0));
    pre(4, 32'h9000_3000, 10, 32'h7b41_92c0, 3'h0);
    exec(ex(6, 4, 10, 1'b0, 1'b1));
    pre(4, 32'h1000_0400, 10, 32'hefff_ffff, 3'h5);
    exec(ex(6, 4, 10, 1'b1, 1'b0));
    pre(4, 32'h8000_0000, 10, 32'h8000_7000, 3'h0);
    exec(ex(6, 4, 10, 1'b1, 1'b1));
    pre(5, 32'h0000_0900, 0, 32'h1234_5678, 3'h7);
    exec(im(6'h0e, 4, 5, 16'h8ff0));
    exec(im(6'h0e, 3, 0, 16'h8000));
    exec(im(6'h0f, 7, 0, 16'h0011));
    pre(4, 32'h0000_2346, 6, 32'h0000_4000, 3'h0);
    exec(im(6'h0c, 9, 4, 16'hffff));
    exec(im(6'h0f, 7, 6, 16'h0011));
    pre(4, 32'hefff_ffff, 0, 32'h0000_0005, 3'h4);
    exec(im(6'h0d, 6, 4, 16'h1000));
    exec(im(6'h0c, 8, 0, 16'h0001));
    exec(im(6'h00, 1, 2, 16'h0000));
    exec({6'h1f, 15'h0, 1'b0, 9'h089, 1'b0});
    done("directed forms");
    for (int n = 0; n < 48; n++) begin
      v = rnd();
      op = ops[v[2:0] % 5];
      pre(v[7:3], rnd(), v[12:8], rnd(), v[15:13]);
      if (op == 6'h1f) begin
        exec(ex(v[20:16], v[7:3], v[12:8], v[21], v[22]));
      end else begin
        exec(im(op, v[20:16], v[7:3], v[31:16]));
      end
    end
    done("random forms");
    wr(fpa_pkg::OFF_IRQ_EN, 32'h7);
    irqc(3'h7);
    wr(fpa_pkg::OFF_IRQ_CLR, 32'h7);
    stat = 3'h0;
    irqc(3'h7);
    exec(32'h0000_0000);
    irqc(3'h7);
    wr(fpa_pkg::OFF_IRQ_EN, 32'h3);
    irqc(3'h3);
    wr(fpa_pkg::OFF_IRQ_EN, 32'h4);
    irqc(3'h4);
    done("interrupt");
    results();
  end
endmodule
`default_nettype wire
